//--- src/an_status_pkg.sv
// package for the upper status word of the auto-negotiation results
// shared by the status block and its remote fault latch
package an_status_pkg;
    localparam int LP_WIDTH = 16;
    // link partner base page field positions
    localparam int LP_RF_HI = 13;
    localparam int LP_RF_LO = 12;
    localparam int LP_LINK_BIT = 15;
    localparam int LP_SPD_HI = 11;
    localparam int LP_SPD_LO = 10;
    localparam int LP_DUP_X = 5;
    localparam int LP_DUP_SG = 12;
    localparam int LP_PAUSE_HI = 8;
    localparam int LP_PAUSE_LO = 7;
    // upper status word field positions
    localparam int ST_WIDTH = 8;
    localparam int FLD_W = 2;
    localparam int ST_RF_LO = 0;
    localparam int ST_SPD_LO = 2;
    localparam int ST_DUP = 4;
    localparam int ST_FLT = 5;
    localparam int ST_PAUSE_LO = 6;
    // encodings
    localparam logic [1:0] RF_NONE = 2'h0;
    localparam logic [1:0] RF_LINK_FAIL = 2'h2;
    localparam logic [1:0] SPD_1000 = 2'h2;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_RSVD = 2'h3;
    localparam logic [1:0] PAUSE_NONE = 2'h0;
    localparam logic [1:0] PAUSE_SYM = 2'h1;
    localparam logic [1:0] PAUSE_ASYM = 2'h2;
    localparam logic [1:0] PAUSE_BOTH = 2'h3;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    typedef enum logic [1:0] {
        MODE_BASEX,
        MODE_SGMII_MAC,
        MODE_SGMII_PHY
    } link_mode_e;
endpackage

//--- src/remote_fault_latch.sv
// sticky remote fault flag, cleared by a management read of register 1
// assumes fault detect and read strobe are on sys_clk_i
`timescale 1ns/10ps
`default_nettype none
module remote_fault_latch (
    input wire logic sys_clk_i, // core clock
    input wire logic rstn_i, // async reset, active low
    input wire logic fault_i, // fault seen this cycle
    input wire logic status_read_i, // read of status register 1
    output logic flag_o // latched fault flag
);
    import an_status_pkg::*;
    typedef struct packed {
        logic flag;
    } state_s;
    state_s st;
    state_s next_st;
    // =====================================================
    // latch: set wins over the clear
    always_comb begin
        next_st = st;
        if (fault_i) begin
            next_st.flag = 1'b1;
        end else if (status_read_i) begin
            next_st.flag = 1'b0;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign flag_o = st.flag;
endmodule // remote_fault_latch
`default_nettype wire

//--- src/an_status_upper.sv
// upper status word bits 15:8: auto-negotiation results
// assumes page and control inputs come from core logic on sys_clk_i
// Summary of operation
// - base-x fault code from partner page 13:12
// - sgmii phy side holds fault code 00
// - sgmii mac side: code 10 when link 0
// - base-x speed field tied to 10
// - sgmii speed codes 10/01/00, 11 reserved
// - sgmii speed from partner or own advert
// - duplex from page bit 5 or 12
// - bit 13 equals management fault bit 1.4
// - fault flag latched, cleared by status read
// - pause bits from partner page 8:7
// - pause codes none/sym/asym/both
`timescale 1ns/10ps
`default_nettype none
module an_status_upper (
    input wire logic sys_clk_i, // core clock 200 MHz
    input wire logic rstn_i, // async reset, active low
    input wire logic sgmii_i, // 1 sgmii, 0 base-x
    input wire logic phy_side_i, // sgmii phy side
    input wire logic an_enable_i, // auto-negotiation on
    input wire logic [an_status_pkg::LP_WIDTH-1:0] lp_page_i, // partner page
    input wire logic [an_status_pkg::LP_WIDTH-1:0] adv_i, // own advert reg 4
    input wire logic status_read_i, // read of register 1
    output logic [7:0] status_o, // status bits 15:8
    output logic fault_flag_o // mirror of register bit 1.4
);
    import an_status_pkg::*;
    typedef struct packed {
        logic [7:0] word;
    } state_s;
    state_s st;
    state_s next_st;
    link_mode_e mode;
    logic fault_now;
    logic flag;
    logic [1:0] rf_code;
    logic [1:0] spd_code;
    logic dup_bit;
    logic [1:0] pause_code;
    logic flag_upd;

    // =====================================================
    // elaboration checks: the field helpers rely on these
    if (LP_WIDTH <= LP_LINK_BIT) begin : g_chk_width
        $error("partner page too narrow for the link bit");
    end
    if (LP_WIDTH <= LP_DUP_X || LP_WIDTH <= LP_DUP_SG) begin : g_chk_dup
        $error("partner page too narrow for the duplex bits");
    end
    if (LP_RF_HI != LP_RF_LO + FLD_W - 1) begin : g_chk_rf
        $error("fault code field is not two adjacent bits");
    end
    if (LP_SPD_HI != LP_SPD_LO + FLD_W - 1) begin : g_chk_spd
        $error("speed field is not two adjacent bits");
    end
    if (LP_PAUSE_HI != LP_PAUSE_LO + FLD_W - 1) begin : g_chk_pause
        $error("pause field is not two adjacent bits");
    end
    if (LP_RF_HI >= LP_WIDTH || LP_SPD_HI >= LP_WIDTH ||
        LP_PAUSE_HI >= LP_WIDTH) begin : g_chk_hi
        $error("page fields reach past the page width");
    end
    if (ST_PAUSE_LO + FLD_W > ST_WIDTH) begin : g_chk_word
        $error("status fields do not fit the output word");
    end
    if (ST_DUP >= ST_FLT || ST_FLT >= ST_PAUSE_LO) begin : g_chk_order
        $error("status fields overlap");
    end
    if (RF_NONE == RF_LINK_FAIL) begin : g_chk_rf_code
        $error("fault codes must differ");
    end
    if (SPD_100 == SPD_1000 || SPD_10 == SPD_1000) begin : g_chk_spd_code
        $error("speed codes must differ");
    end
    if (ST_WIDTH != $bits(status_o)) begin : g_chk_port
        $error("status port width differs from the word");
    end
    if ($bits(STATUS_RESET) != ST_WIDTH) begin : g_chk_reset
        $error("reset value width differs from the word");
    end

    // =====================================================
    // field helpers
    // two-bit field starting at bit lo
    function automatic logic [1:0] fld(input logic [LP_WIDTH-1:0] v,
                                       input int lo);
        fld = v[lo+:FLD_W];
    endfunction

    // strap decode: base-x ignores the side strap
    function automatic link_mode_e mode_of(input logic sgmii,
            input logic phy);
        link_mode_e m;
        if (!sgmii) begin
            m = MODE_BASEX;
        end else if (phy) begin
            m = MODE_SGMII_PHY;
        end else begin
            m = MODE_SGMII_MAC;
        end
        return m;
    endfunction

    // remote fault type for bits 9:8
    function automatic logic [1:0] fault_code(input link_mode_e m,
            input logic [LP_WIDTH-1:0] p);
        logic [1:0] c;
        case (m)
            MODE_BASEX: c = fld(p, LP_RF_LO);
            MODE_SGMII_MAC: begin
                c = p[LP_LINK_BIT] ? RF_NONE : RF_LINK_FAIL;
            end
            default: c = RF_NONE;
        endcase
        return c;
    endfunction

    // speed for bits 11:10; sgmii codes pass through as sent
    function automatic logic [1:0] speed_code(input link_mode_e m,
            input logic [LP_WIDTH-1:0] p,
            input logic [LP_WIDTH-1:0] a);
        logic [1:0] s;
        case (m)
            MODE_BASEX: s = SPD_1000;
            MODE_SGMII_MAC: s = fld(p, LP_SPD_LO);
            default: s = fld(a, LP_SPD_LO);
        endcase
        return s;
    endfunction

    // duplex bit 12: 1 full, 0 half
    function automatic logic duplex_bit(input link_mode_e m,
            input logic [LP_WIDTH-1:0] p);
        logic d;
        if (m == MODE_BASEX) begin
            d = p[LP_DUP_X];
        end else begin
            d = p[LP_DUP_SG];
        end
        return d;
    endfunction

    // fault condition; the phy side never reports one
    function automatic logic fault_seen(input link_mode_e m,
            input logic an,
            input logic [LP_WIDTH-1:0] p);
        logic f;
        case (m)
            MODE_BASEX: f = an && (fld(p, LP_RF_LO) != RF_NONE);
            MODE_SGMII_MAC: f = an && !p[LP_LINK_BIT];
            default: f = 1'b0;
        endcase
        return f;
    endfunction

    // next flag value: a new fault wins over the clearing read
    function automatic logic flag_next(input logic cur,
            input logic seen,
            input logic rd);
        logic n;
        if (seen) begin
            n = 1'b1;
        end else if (rd) begin
            n = 1'b0;
        end else begin
            n = cur;
        end
        return n;
    endfunction

    // =====================================================
    // mode, fault and field decode
    always_comb begin
        mode = mode_of(sgmii_i, phy_side_i);
        fault_now = fault_seen(mode, an_enable_i, lp_page_i);
        rf_code = fault_code(mode, lp_page_i);
        spd_code = speed_code(mode, lp_page_i, adv_i);
        dup_bit = duplex_bit(mode, lp_page_i);
        pause_code = fld(lp_page_i, LP_PAUSE_LO);
        flag_upd = flag_next(flag, fault_now, status_read_i);
    end

    // register bit 1.4 lives in the latch
    remote_fault_latch u_fault (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .fault_i(fault_now),
        .status_read_i(status_read_i),
        .flag_o(flag)
    );

    // =====================================================
    // status word assembly
    // bit 13 takes the latch's next value, so it never
    // trails register bit 1.4 by a cycle
    always_comb begin
        next_st = st;
        next_st.word[ST_RF_LO+:FLD_W] = rf_code;
        next_st.word[ST_SPD_LO+:FLD_W] = spd_code;
        next_st.word[ST_DUP] = dup_bit;
        next_st.word[ST_FLT] = flag_upd;
        next_st.word[ST_PAUSE_LO+:FLD_W] = pause_code;
    end

    // every field moves on the clock edge; the async reset clears the word at once
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st.word <= STATUS_RESET;
        end else begin
            st <= next_st;
        end
    end

    // =====================================================
    // outputs
    assign status_o = st.word;
    assign fault_flag_o = flag;
endmodule // an_status_upper
`default_nettype wire

//--- verif/link_partner.sv
// link partner model: registers the page it advertises
// bench hands it the next page on the falling edge
`timescale 1ns/10ps
`default_nettype none
module link_partner (
    input wire logic sys_clk_i, // clock
    input wire logic [15:0] next_page_i, // page to send
    output logic [15:0] lp_page_o // registered page
);
    always_ff @(negedge sys_clk_i) lp_page_o <= next_page_i;
endmodule // link_partner
`default_nettype wire

//--- verif/an_status_asserts.sv
// checker on the ports of an_status_upper
// single clock domain, bound into the design
`timescale 1ns/10ps
`default_nettype none
module an_status_chk (
    input wire logic sys_clk_i, // clock
    input wire logic rstn_i, // reset
    input wire logic sgmii_i, // mode
    input wire logic phy_side_i, // side
    input wire logic an_enable_i, // an on
    input wire logic [15:0] lp_page_i, // page
    input wire logic [15:0] adv_i, // advert
    input wire logic status_read_i, // read
    input wire logic [7:0] status_o, // word
    input wire logic fault_flag_o // flag
);
    wire logic [1:0] spd = phy_side_i ? adv_i[11:10] : lp_page_i[11:10];
    wire logic dup = sgmii_i ? lp_page_i[12] : lp_page_i[5];
    wire logic [1:0] rf = lp_page_i[13:12];
    wire logic mac_dn = sgmii_i & ~phy_side_i & ~lp_page_i[15] & an_enable_i;
    wire logic flt = an_enable_i & (sgmii_i ? ~phy_side_i & ~lp_page_i[15]
        : |lp_page_i[13:12]);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    // ========
    // checks
    chk_bx_spd: assert property (!sgmii_i |=> status_o[3:2] == 2'h2)
        else $error("speed");
    chk_sgmii_spd:
        assert property (sgmii_i |=> status_o[3:2] == $past(spd))
        else $error("sgmii speed");
    chk_phy_code:
        assert property (sgmii_i & phy_side_i |=> !status_o[1:0])
        else $error("phy code");
    chk_mac_code:
        assert property (mac_dn |=> status_o[1:0] == 2'h2)
        else $error("mac code");
    chk_bx_rf:
        assert property (!sgmii_i & an_enable_i |=> status_o[1:0] == $past(rf))
        else $error("basex code");
    chk_dup_bit:
        assert property (1 |=> status_o[4] == $past(dup))
        else $error("duplex");
    chk_flag_copy:
        assert property (status_o[5] == fault_flag_o)
        else $error("flag copy");
    chk_flag_hold:
        assert property (fault_flag_o && !status_read_i |=> fault_flag_o)
        else $error("flag lost");
    chk_flag_set:
        assert property (flt |=> fault_flag_o)
        else $error("flag not set");
    chk_flag_clear:
        assert property (status_read_i && !flt |=> !fault_flag_o)
        else $error("flag not cleared");
    chk_pause_bits:
        assert property (1 |=> status_o[7:6] == $past(lp_page_i[8:7]))
        else $error("pause");
    cov_clear: cover property (fault_flag_o && status_read_i);
    cov_bx_fault: cover property (flt && !sgmii_i);
    cov_mac: cover property (mac_dn);
    cov_phy: cover property (sgmii_i && phy_side_i);
endmodule // an_status_chk
bind an_status_upper an_status_chk an_status_chk_inst (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .sgmii_i(sgmii_i), .phy_side_i(phy_side_i),
    .an_enable_i(an_enable_i), .lp_page_i(lp_page_i), .adv_i(adv_i),
    .status_read_i(status_read_i), .status_o(status_o),
    .fault_flag_o(fault_flag_o));
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for an_status_upper
// inputs change just after the falling edge; partner supplies the page
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic sys_clk_i, rstn_i, sgmii_i, phy_side_i, an_enable_i, status_read_i;
    logic [15:0] lp_page_i, adv_i, next_page, rnd;
    logic [7:0] status_o, exp_w, msk;
    logic fault_flag_o, eflag;
    int error_cnt, total_checks, cycles;
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    link_partner link_partner_inst (.sys_clk_i(sys_clk_i),
        .next_page_i(next_page), .lp_page_o(lp_page_i));
    an_status_upper an_status_upper_inst (.sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i), .sgmii_i(sgmii_i), .phy_side_i(phy_side_i),
        .an_enable_i(an_enable_i), .lp_page_i(lp_page_i), .adv_i(adv_i),
        .status_read_i(status_read_i), .status_o(status_o),
        .fault_flag_o(fault_flag_o));
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] expect_word(logic [15:0] p, logic f);
        logic [1:0] rf;
        rf = !sgmii_i ? p[13:12] : (phy_side_i || p[15] ? 2'h0 : 2'h2);
        return {p[8:7], f, sgmii_i ? p[12] : p[5],
            !sgmii_i ? 2'h2 : (phy_side_i ? adv_i[11:10] : p[11:10]), rf};
    endfunction
    task automatic check(logic [7:0] seen, logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("BAD %0t saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // ========
    // random traffic, zero pages first
    initial begin
        {rstn_i, sgmii_i, phy_side_i, an_enable_i, status_read_i} = 5'h00;
        adv_i = 16'h0000;
        next_page = 16'h0000;
        rnd = 16'h0014;
        eflag = 1'b0;
        repeat (16) @(negedge sys_clk_i);
        #1 rstn_i = 1'b1;
        for (int i = 0; i < 600; i++) begin
            if (i > 0) begin
                check(status_o & msk, exp_w & msk);
                check({7'h00, fault_flag_o}, {7'h00, eflag});
            end
            rnd = lfsr(rnd);
            {sgmii_i, phy_side_i, an_enable_i} = rnd[2:0];
            status_read_i = &rnd[4:3];
            adv_i = {rnd[7:0], rnd[15:8]};
            next_page = (i < 8) ? 16'h0000 : lfsr(rnd);
            eflag = an_enable_i && (sgmii_i ? !phy_side_i && !lp_page_i[15]
                : |lp_page_i[13:12]) || eflag && !status_read_i;
            exp_w = expect_word(lp_page_i, eflag);
            msk = (sgmii_i || an_enable_i) ? 8'hff : 8'hfc;
            @(negedge sys_clk_i);
            #1;
        end
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
